// file: rtl/tdm_serial_timing.v
`timescale 1ns/1ps
`default_nettype none
`include "tdm_switch_defs.vh"

// recovers bit and channel position from the synchronised bit clock and frame pulse
module tdm_serial_timing (
  input  wire       sys_clk_i,
  input  wire       reset_n_i,
  input  wire       bclk_n_i,
  input  wire       frame_n_i,
  output reg        sample_o,
  output reg        shift_o,
  output reg  [2:0] bit_idx_o,
  output reg  [4:0] chan_o,
  output reg        frame_start_o
);
  reg       bclk_q_reg;
  reg       half_reg;
  reg       frame_seen_reg;
  wire      rise;
  wire      fall;

  assign rise = bclk_n_i & ~bclk_q_reg;
  assign fall = ~bclk_n_i & bclk_q_reg;

  // two link-clock cycles per bit: shift on one half, sample on the other
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bclk_q_reg     <= 1'b1;
      half_reg       <= 1'b0;
      frame_seen_reg <= 1'b0;
      sample_o       <= 1'b0;
      shift_o        <= 1'b0;
      bit_idx_o      <= 3'h7;
      chan_o         <= 5'h00;
      frame_start_o  <= 1'b0;
    end else begin
      bclk_q_reg    <= bclk_n_i;
      sample_o      <= 1'b0;
      shift_o       <= 1'b0;
      frame_start_o <= 1'b0;
      if (fall) begin
        if (!frame_n_i) begin
          frame_seen_reg <= 1'b1;
        end
      end
      if (rise) begin
        if (frame_seen_reg) begin
          frame_seen_reg <= 1'b0;
          half_reg       <= 1'b1;
          bit_idx_o      <= 3'h7;
          chan_o         <= 5'h00;
          shift_o        <= 1'b1;
          frame_start_o  <= 1'b1;
        end else if (half_reg) begin
          half_reg <= 1'b0;
          sample_o <= 1'b1;
        end else begin
          half_reg <= 1'b1;
          shift_o  <= 1'b1;
          if (bit_idx_o == 3'h0) begin
            bit_idx_o <= 3'h7;
            chan_o    <= chan_o + 5'h01;
          end else begin
            bit_idx_o <= bit_idx_o - 3'h1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/tdm_time_slot_switch.v
// Operation
// RULE1: lanes run continuously, frames of 32 eight-bit channels
// RULE2: received bytes stored in 256-byte memory per lane and channel, readable
// RULE3: switched channel reads input memory at its low connection byte
// RULE4: message channel transmits its low connection byte every frame
// RULE5: port has 6-bit address, 8-bit data, select, direction, strobe, acknowledge
// RULE6: top address bit low always reaches the control register
// RULE7: top address bit high selects channel in memory and lane from control
// RULE8: control register readable and writable, gives upper memory address bits
// RULE9: split bit: reads from input memory, writes to low connection memory
// RULE10: broadcast bit makes every channel transmit its low connection byte
// RULE11: select field 01 input memory, 10 low, 11 high; 00 unused
// RULE12: control bits 2-0 pick the lane section
// RULE13: high connection bit 2 puts channel into message operation
// RULE14: low connection bits 7-5 source lane, 4-0 source channel
// RULE15: drive enable low tri-states every output lane
// RULE16: drive enable high with broadcast drives all lanes
// RULE17: otherwise high connection bit 0 enables each lane and channel
// RULE18: high connection bit 1 sent on control pin one channel early; the lane 0 bit goes out in its own channel instead
// RULE19: control bits sent lane 0 first, aligned with bits 7 to 0
// RULE20: lane timing derived only from external bit clock and frame pulse
// RULE21: control write is fast; other accesses wait for acknowledge
// RULE22: acknowledge asserted while select and strobe held; processor releases after
// RULE23: bit clock is twice the bit rate, frame pulse active low
`timescale 1ns/1ps
`default_nettype none
`include "tdm_switch_defs.vh"

module tdm_time_slot_switch #(
  parameter LANES    = `LANES,
  parameter CHANNELS = `CHANNELS
) (
  input  wire        sys_clk_i,
  input  wire        reset_n_i,
  input  wire [5:0]  addr_i,
  input  wire [7:0]  data_i,
  output reg  [7:0]  data_o,
  output wire        data_oe_o,
  input  wire        select_n_i,
  input  wire        read_write_i,
  input  wire        port_strobe_i,
  output wire        transfer_ack_n_o,
  input  wire [7:0]  serial_in_lane_i,
  output reg  [7:0]  serial_out_lane_o,
  output reg  [7:0]  serial_out_lane_oe_o,
  output reg         control_bit_out_o,
  input  wire        output_drive_enable_i,
  input  wire        bit_clock_in_n_i,
  input  wire        frame_pulse_in_n_i
);
  // data memory, low and high connection memories: index is {lane, channel}
  reg [7:0] data_mem   [0:LANES*CHANNELS-1];
  reg [7:0] conn_low   [0:LANES*CHANNELS-1];
  reg [2:0] conn_high  [0:LANES*CHANNELS-1];

  reg  [7:0] switch_control_reg;
  reg  [7:0] in_sync1_reg;
  reg  [7:0] in_sync2_reg;
  reg  [7:0] shift_in_reg [0:LANES-1];
  reg  [7:0] tx_byte_reg  [0:LANES-1];
  reg  [7:0] tx_oe_reg;
  reg  [7:0] cbit_reg;
  reg  [1:0] ctl_sync1_reg;
  reg  [1:0] ctl_sync2_reg;
  reg  [4:0] port_sync1_reg;
  reg  [4:0] port_sync2_reg;
  reg  [5:0] addr_sync1_reg;
  reg  [5:0] addr_sync2_reg;
  reg  [7:0] wdata_sync1_reg;
  reg  [7:0] wdata_sync2_reg;
  reg  [3:0] wait_reg;
  reg  [1:0] state_reg;
  reg  [3:0] load_lane_reg;
  reg        loading_reg;
  reg        ode_sync1_reg;
  reg        ode_sync2_reg;

  wire       sample;
  wire       shift;
  wire [2:0] bit_idx;
  wire [4:0] chan;
  wire       frame_start;
  wire       sel_q;
  wire       rw_q;
  wire       strobe_q;
  wire       access;
  wire       broadcast;
  wire [4:0] next_chan;
  integer    i;
  integer    wr_lane;
  integer    tx_lane;
  integer    out_lane;

  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_ACK  = 2'h2;

  function [7:0] mem_index;
    input [2:0] lane;
    input [4:0] ch;
    begin
      mem_index = {lane, ch};
    end
  endfunction

  tdm_serial_timing u_timing (
    .sys_clk_i    (sys_clk_i),
    .reset_n_i    (reset_n_i),
    .bclk_n_i     (ctl_sync2_reg[0]),
    .frame_n_i    (ctl_sync2_reg[1]),
    .sample_o     (sample),
    .shift_o      (shift),
    .bit_idx_o    (bit_idx),
    .chan_o       (chan),
    .frame_start_o(frame_start)
  );

  assign sel_q     = ~port_sync2_reg[0];
  assign rw_q      = port_sync2_reg[1];
  assign strobe_q  = port_sync2_reg[2];
  assign access    = sel_q & strobe_q;
  assign broadcast = switch_control_reg[`CTRL_BCAST_BIT];
  assign next_chan = chan + 5'h01;
  assign data_oe_o = (state_reg == ST_ACK) & rw_q & access; // RULE5
  assign transfer_ack_n_o = ~((state_reg == ST_ACK) & access); // RULE22

  // all pins from outside the clock domain pass two flip-flops
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      in_sync1_reg    <= 8'h00;
      in_sync2_reg    <= 8'h00;
      ctl_sync1_reg   <= 2'h3;
      ctl_sync2_reg   <= 2'h3;
      port_sync1_reg  <= 5'h01;
      port_sync2_reg  <= 5'h01;
      addr_sync1_reg  <= 6'h00;
      addr_sync2_reg  <= 6'h00;
      wdata_sync1_reg <= 8'h00;
      wdata_sync2_reg <= 8'h00;
      ode_sync1_reg   <= 1'b0;
      ode_sync2_reg   <= 1'b0;
    end else begin
      in_sync1_reg    <= serial_in_lane_i;
      in_sync2_reg    <= in_sync1_reg;
      ctl_sync1_reg   <= {frame_pulse_in_n_i, bit_clock_in_n_i}; // RULE20
      ctl_sync2_reg   <= ctl_sync1_reg;
      port_sync1_reg  <= {2'h0, port_strobe_i, read_write_i, select_n_i};
      port_sync2_reg  <= port_sync1_reg;
      addr_sync1_reg  <= addr_i;
      addr_sync2_reg  <= addr_sync1_reg;
      wdata_sync1_reg <= data_i;
      wdata_sync2_reg <= wdata_sync1_reg;
      ode_sync1_reg   <= output_drive_enable_i;
      ode_sync2_reg   <= ode_sync1_reg;
    end
  end

  // receive: shift in per lane, store at the last bit of each channel
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (i = 0; i < LANES; i = i + 1) begin
        shift_in_reg[i] <= 8'h00;
      end
    end else if (sample) begin
      for (i = 0; i < LANES; i = i + 1) begin
        shift_in_reg[i] <= {shift_in_reg[i][6:0], in_sync2_reg[i]}; // RULE1
      end
    end
  end

  always @(posedge sys_clk_i) begin
    if (sample && bit_idx == 3'h0) begin
      for (wr_lane = 0; wr_lane < LANES; wr_lane = wr_lane + 1) begin
        data_mem[mem_index(wr_lane[2:0], chan)] <= {shift_in_reg[wr_lane][6:0], in_sync2_reg[wr_lane]}; // RULE2
      end
    end
  end

  // transmit: one lane per cycle is loaded for the next channel after the last
  // bit of the current one is sampled, so bit 7 goes out with the right byte
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      loading_reg   <= 1'b0;
      load_lane_reg <= 4'h0;
      tx_oe_reg     <= 8'h00;
      for (tx_lane = 0; tx_lane < LANES; tx_lane = tx_lane + 1) begin
        tx_byte_reg[tx_lane] <= 8'h00;
      end
    end else begin
      if (sample && bit_idx == 3'h0) begin
        loading_reg   <= 1'b1;
        load_lane_reg <= 4'h0;
      end else if (loading_reg) begin
        if (broadcast || conn_high[mem_index(load_lane_reg[2:0], next_chan)][`HIGH_MSG_BIT]) begin
          tx_byte_reg[load_lane_reg[2:0]] <= conn_low[mem_index(load_lane_reg[2:0], next_chan)]; // RULE4 RULE10 RULE13
        end else begin
          tx_byte_reg[load_lane_reg[2:0]] <=
            data_mem[conn_low[mem_index(load_lane_reg[2:0], next_chan)]]; // RULE3 RULE14
        end
        tx_oe_reg[load_lane_reg[2:0]] <= broadcast |
          conn_high[mem_index(load_lane_reg[2:0], next_chan)][`HIGH_OE_BIT]; // RULE16 RULE17
        if (load_lane_reg == 4'h7) begin
          loading_reg <= 1'b0;
        end
        load_lane_reg <= load_lane_reg + 4'h1;
      end
    end
  end

  // serial outputs and control bit, updated on the shift half of each bit
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      serial_out_lane_o    <= 8'h00;
      serial_out_lane_oe_o <= 8'h00;
      control_bit_out_o    <= 1'b0;
      cbit_reg             <= 8'h00;
    end else begin
      if (!ode_sync2_reg) begin
        serial_out_lane_oe_o <= 8'h00; // RULE15
      end
      if (shift && loading_reg == 1'b0 && bit_idx == 3'h7) begin
        for (out_lane = 0; out_lane < LANES; out_lane = out_lane + 1) begin
          cbit_reg[out_lane] <= conn_high[mem_index(out_lane[2:0], next_chan)][`HIGH_CBIT_BIT]; // RULE18
        end
      end
      if (shift) begin
        for (out_lane = 0; out_lane < LANES; out_lane = out_lane + 1) begin
          serial_out_lane_o[out_lane] <= tx_byte_reg[out_lane][bit_idx];
        end
        control_bit_out_o <= cbit_reg[3'h7 - bit_idx]; // RULE19
      end
      // enables follow the channel boundary, not the early load
      if (ode_sync2_reg && shift) begin
        serial_out_lane_oe_o <= tx_oe_reg;
      end
    end
  end

  // processor port: control write is fast, everything else waits
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg          <= ST_IDLE;
      wait_reg           <= 4'h0;
      switch_control_reg <= `CTRL_RESET_VAL;
      data_o             <= 8'h00;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (access) begin
            if (!addr_sync2_reg[`ADDR_MEM_BIT] && !rw_q) begin // RULE6
              switch_control_reg <= wdata_sync2_reg; // RULE8 RULE21
              state_reg          <= ST_ACK;
            end else begin
              wait_reg  <= `ACK_WAIT_CYCLES;
              state_reg <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (wait_reg != 4'h0) begin
            wait_reg <= wait_reg - 4'h1;
          end else begin
            state_reg <= ST_ACK;
            if (rw_q && !addr_sync2_reg[`ADDR_MEM_BIT]) begin
              data_o <= switch_control_reg; // RULE8
            end else if (rw_q) begin
              if (switch_control_reg[`CTRL_SPLIT_BIT] ||
                  switch_control_reg[`CTRL_SEL_HI:`CTRL_SEL_LO] == `SEL_DATA_MEM) begin // RULE9 RULE11
                data_o <= data_mem[mem_index(switch_control_reg[`CTRL_LANE_HI:`CTRL_LANE_LO],
                                             addr_sync2_reg[4:0])]; // RULE7 RULE12
              end else if (switch_control_reg[`CTRL_SEL_HI:`CTRL_SEL_LO] == `SEL_CONN_LOW) begin
                data_o <= conn_low[mem_index(switch_control_reg[`CTRL_LANE_HI:`CTRL_LANE_LO],
                                             addr_sync2_reg[4:0])];
              end else begin
                data_o <= {5'h00, conn_high[mem_index(switch_control_reg[`CTRL_LANE_HI:`CTRL_LANE_LO],
                                                      addr_sync2_reg[4:0])]};
              end
            end
          end
        end
        ST_ACK: begin
          if (!access) begin
            state_reg <= ST_IDLE; // RULE22
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // memory writes from the port; the input memory is read-only here
  always @(posedge sys_clk_i) begin
    if (state_reg == ST_WAIT && wait_reg == 4'h0 && !rw_q) begin
      if (switch_control_reg[`CTRL_SPLIT_BIT] ||
          switch_control_reg[`CTRL_SEL_HI:`CTRL_SEL_LO] == `SEL_CONN_LOW) begin // RULE9
        conn_low[mem_index(switch_control_reg[`CTRL_LANE_HI:`CTRL_LANE_LO], addr_sync2_reg[4:0])]
          <= wdata_sync2_reg;
      end else if (switch_control_reg[`CTRL_SEL_HI:`CTRL_SEL_LO] == `SEL_CONN_HIGH) begin // RULE11
        conn_high[mem_index(switch_control_reg[`CTRL_LANE_HI:`CTRL_LANE_LO], addr_sync2_reg[4:0])]
          <= wdata_sync2_reg[2:0];
      end
    end
  end
endmodule
`default_nettype wire

// file: shared/tdm_switch_defs.vh
`ifndef TDM_SWITCH_DEFS_VH
`define TDM_SWITCH_DEFS_VH

`define LANES            8
`define CHANNELS         32
`define BITS_PER_CHANNEL 8
`define CTRL_SPLIT_BIT   7
`define CTRL_BCAST_BIT   6
`define CTRL_SEL_HI      4
`define CTRL_SEL_LO      3
`define CTRL_LANE_HI     2
`define CTRL_LANE_LO     0
`define SEL_DATA_MEM     2'h1
`define SEL_CONN_LOW     2'h2
`define SEL_CONN_HIGH    2'h3
`define CTRL_RESET_VAL   8'h00
`define HIGH_MSG_BIT     2
`define HIGH_CBIT_BIT    1
`define HIGH_OE_BIT      0
`define ADDR_MEM_BIT     5
`define ACK_WAIT_CYCLES  4'h3

`endif

// file: verif/tb_tdm_time_slot_switch.sv
`timescale 1ns/1ps
`default_nettype none
`include "tdm_switch_defs.vh"
module tb_tdm_time_slot_switch;
  logic       sys_clk_i = 1'b0;
  logic       reset_n_i = 1'b0;
  logic [5:0] addr_i = 6'h00;
  logic [7:0] data_i = 8'h00;
  logic       select_n_i = 1'b1;
  logic       read_write_i = 1'b1;
  logic       port_strobe_i = 1'b0;
  logic       ode_i = 1'b0;
  logic [7:0] rd;
  wire  [7:0] data_o, sin, sout, soe, fcnt;
  wire        data_oe_o, ack_n, cbit, bclk_n, frame_n;
  int         bad_count = 0;
  int         checks = 0;
  always #2.5 sys_clk_i = ~sys_clk_i;
  tdm_time_slot_switch tdm_time_slot_switch_inst (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o), .select_n_i(select_n_i), .read_write_i(read_write_i),
    .port_strobe_i(port_strobe_i), .transfer_ack_n_o(ack_n), .serial_in_lane_i(sin), .serial_out_lane_o(sout),
    .serial_out_lane_oe_o(soe), .control_bit_out_o(cbit), .output_drive_enable_i(ode_i),
    .bit_clock_in_n_i(bclk_n), .frame_pulse_in_n_i(frame_n));
  tdm_lane_partner tdm_lane_partner_inst (.bclk_n_o(bclk_n), .frame_n_o(frame_n), .sin_o(sin), .sout_i(sout),
    .soe_i(soe), .cbit_i(cbit), .frame_cnt_o(fcnt));
  task automatic conclude;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check1(input logic got, input logic exp);
    check8({7'h00, got}, {7'h00, exp});
  endtask
  // request held until acknowledge is sampled low, released only afterwards
  task automatic access(input logic rw, input logic [5:0] a, input logic [7:0] d);
    int n;
    @(negedge sys_clk_i);
    read_write_i = rw;
    addr_i = a;
    data_i = d;
    select_n_i = 1'b0;
    port_strobe_i = 1'b1;
    n = 0;
    @(negedge sys_clk_i);
    while (ack_n !== 1'b0 && n < 50) begin
      @(negedge sys_clk_i);
      n++;
    end
    rd = data_o;
    select_n_i = 1'b1;
    port_strobe_i = 1'b0;
    while (ack_n !== 1'b1 && n < 100) begin
      @(negedge sys_clk_i);
      n++;
    end
    check1(n < 100, 1'b1);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    access(1'b0, a, d);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    access(1'b1, a, 8'h00);
    check8(rd, exp);
  endtask
  task automatic wait_frames(input logic [7:0] n);
    logic [7:0] tgt;
    tgt = fcnt + n;
    for (int i = 0; i < 10000 * n && fcnt !== tgt; i++)
      @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask
  initial begin
    #450000;
    bad_count++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    repeat (4) @(posedge sys_clk_i);
    check1(ack_n, 1'b1);
    check1(data_oe_o, 1'b0);
    rd_chk(6'h00, `CTRL_RESET_VAL);
    wr(6'h05, 8'h1A);
    rd_chk(6'h1F, 8'h1A);
    wr(6'h00, 8'h18);
    wr(6'h25, 8'h05);
    wr(6'h26, 8'h01);
    wr(6'h27, 8'h00);
    rd_chk(6'h25, 8'h05);
    wr(6'h00, 8'h1A);
    wr(6'h29, 8'hFA);
    rd_chk(6'h29, 8'h02);
    wr(6'h00, 8'h19);
    wr(6'h29, 8'h00);
    wr(6'h00, 8'h10);
    wr(6'h25, 8'hA5);
    wr(6'h26, 8'h67);
    rd_chk(6'h26, 8'h67);
    wait_frames(8'h03);
    wr(6'h00, 8'h0B);
    rd_chk(6'h27, 8'h98);
    wr(6'h27, 8'h00);
    rd_chk(6'h27, 8'h98);
    wr(6'h00, 8'h83);
    rd_chk(6'h27, 8'h98);
    wr(6'h28, 8'h3C);
    wr(6'h00, 8'h13);
    rd_chk(6'h28, 8'h3C);
    wr(6'h00, 8'h00);
    ode_i = 1'b1;
    wait_frames(8'h02);
    check8(tdm_lane_partner_inst.cap[0][5], 8'hA5);
    check8(tdm_lane_partner_inst.cap[0][6], 8'h98);
    check1(tdm_lane_partner_inst.en[0][6], 1'b1);
    check1(tdm_lane_partner_inst.en[0][7], 1'b0);
    check1(tdm_lane_partner_inst.cb[66], 1'b1);
    check1(tdm_lane_partner_inst.cb[65], 1'b0);
    wr(6'h00, 8'h40);
    wait_frames(8'h02);
    check1(tdm_lane_partner_inst.en[0][7], 1'b1);
    check8(tdm_lane_partner_inst.cap[0][6], 8'h67);
    ode_i = 1'b0;
    wait_frames(8'h02);
    check1(tdm_lane_partner_inst.en[0][5], 1'b0);
    conclude();
  end
endmodule
bind tdm_time_slot_switch tdm_switch_monitor monitor_inst (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
  .addr_i(addr_i), .read_write_i(read_write_i), .select_n_i(select_n_i), .port_strobe_i(port_strobe_i),
  .transfer_ack_n_o(transfer_ack_n_o), .data_o(data_o), .data_oe_o(data_oe_o),
  .serial_out_lane_oe_o(serial_out_lane_oe_o), .output_drive_enable_i(output_drive_enable_i));
`default_nettype wire

// file: verif/tdm_lane_partner.sv
`timescale 1ns/1ps
`default_nettype none
module tdm_lane_partner (
  output logic       bclk_n_o,
  output logic       frame_n_o,
  output logic [7:0] sin_o,
  input  wire  [7:0] sout_i,
  input  wire  [7:0] soe_i,
  input  wire        cbit_i,
  output logic [7:0] frame_cnt_o
);
  logic [8:0] k;
  logic [7:0] cap [0:7][0:31];
  logic       en  [0:7][0:31];
  logic       cb  [0:255];
  // lane l channel c always carries the inverse of {l,c}
  function automatic logic in_bit(input int l, input logic [8:0] p);
    logic [7:0] v;
    v = ~{l[2:0], p[8:4]};
    return v[3'h7 - p[3:1]];
  endfunction
  initial begin
    bclk_n_o = 1'b0;
    frame_n_o = 1'b1;
    sin_o = 8'h00;
    k = 9'h1FF;
    frame_cnt_o = 8'h00;
  end
  // two bit clock periods per bit; a scaled-down rate keeps the run short
  always #40 bclk_n_o = ~bclk_n_o;
  always @(posedge bclk_n_o) begin
    k = k + 9'h001;
    if (k == 9'h000)
      frame_cnt_o <= frame_cnt_o + 8'h01;
    for (int l = 0; l < 8; l++) begin
      if (!k[0])
        sin_o[l] <= in_bit(l, k);
      else begin
        cap[l][k[8:4]][3'h7 - k[3:1]] <= sout_i[l];
        en[l][k[8:4]] <= soe_i[l];
      end
    end
    if (k[0])
      cb[k[8:1]] <= cbit_i;
  end
  // pulse straddles the frame boundary so exactly one falling edge sees it low
  always @(negedge bclk_n_o)
    frame_n_o <= (k != 9'h1FF);
endmodule
`default_nettype wire

// file: verif/tdm_switch_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tdm_switch_monitor #(
  parameter int ODE_SETTLE = 400
) (
  input wire logic       sys_clk_i,
  input wire logic       reset_n_i,
  input wire logic [5:0] addr_i,
  input wire logic       read_write_i,
  input wire logic       select_n_i,
  input wire logic       port_strobe_i,
  input wire logic       transfer_ack_n_o,
  input wire logic [7:0] data_o,
  input wire logic       data_oe_o,
  input wire logic [7:0] serial_out_lane_oe_o,
  input wire logic       output_drive_enable_i
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic       req_w;
  logic [9:0] ode_low_reg;
  logic [9:0] ode_low_next;
  assign req_w = !select_n_i && port_strobe_i;
  assign ode_low_next = output_drive_enable_i ? 10'h000 : ode_low_reg + {9'h000, ode_low_reg != 10'h3FF};
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      ode_low_reg <= 10'h000;
    else
      ode_low_reg <= ode_low_next;
  end
  sequence new_req_s;
    !req_w ##1 (req_w && transfer_ack_n_o);
  endsequence
  ack_answer_a: assert property (new_req_s |-> ##[1:16] !transfer_ack_n_o) else $error("no acknowledge");
  ctrl_fast_a: assert property ((new_req_s ##0 (!addr_i[5] && !read_write_i)) |-> ##[1:5] !transfer_ack_n_o)
    else $error("control write not fast");
  mem_slow_a: assert property ((new_req_s ##0 (addr_i[5] || read_write_i)) |-> transfer_ack_n_o [*4])
    else $error("memory access acknowledged too early");
  ack_cause_a: assert property (!transfer_ack_n_o |-> req_w || $past(req_w) || $past(req_w, 2) || $past(req_w, 3))
    else $error("acknowledge without request");
  ack_release_a: assert property ((!req_w) [*4] |-> transfer_ack_n_o) else $error("acknowledge held");
  read_drive_a: assert property ((req_w && read_write_i && !transfer_ack_n_o) |-> data_oe_o)
    else $error("read data not driven");
  write_quiet_a: assert property ((req_w && !read_write_i) |-> !data_oe_o) else $error("driven on write");
  read_stable_a: assert property ((!transfer_ack_n_o && $past(!transfer_ack_n_o) && read_write_i) |-> $stable(data_o))
    else $error("read data moved");
  ode_off_a: assert property ((ode_low_reg >= ODE_SETTLE) |-> serial_out_lane_oe_o == 8'h00)
    else $error("lane driven while drive enable low");
  cover property (new_req_s ##0 addr_i[5]);
endmodule
`default_nettype wire
